// file: verilog/uhl_pkg.sv
// constants shared by the frame timing and list pointer register bank
//
// Overview of operation
// - master disable write clears global enable
// - disable bit one clears source, zero keeps
// - fatal error disable bit ignores writes
// - comm area pointer in bits 31:7
// - list descriptor pointers in bits 31:4
// - done head pointer in bits 31:4
// - frame length reset value is 11999
// - largest packet limit loaded each frame
// - running: frame timer counts down at 12MHz
// - timer at zero reloads from frame length
// - timer loads on entry to running state
// - every timer load copies interval toggle
// - frame count increments on load, wraps
// - periodic begin point marks periodic start
// - frame count bit 15 change flags wrap
// - running functional state encoded as 10
// - frame start flagged at each new frame

`default_nettype none

package uhl_pkg;

    // ==================================================================
    // register byte addresses
    localparam logic [31:0] ADDR_IRQ_ENABLE = 32'hB000_7010;
    localparam logic [31:0] ADDR_IRQ_DISABLE = 32'hB000_7014;
    localparam logic [31:0] ADDR_COMM_AREA = 32'hB000_7018;
    localparam logic [31:0] ADDR_PERIODIC_CUR = 32'hB000_701C;
    localparam logic [31:0] ADDR_CONTROL_HEAD = 32'hB000_7020;
    localparam logic [31:0] ADDR_CONTROL_CUR = 32'hB000_7024;
    localparam logic [31:0] ADDR_BULK_HEAD = 32'hB000_7028;
    localparam logic [31:0] ADDR_BULK_CUR = 32'hB000_702C;
    localparam logic [31:0] ADDR_DONE_HEAD = 32'hB000_7030;
    localparam logic [31:0] ADDR_FRAME_INTERVAL = 32'hB000_7034;
    localparam logic [31:0] ADDR_FRAME_LEFT = 32'hB000_7038;
    localparam logic [31:0] ADDR_FRAME_COUNT = 32'hB000_703C;
    localparam logic [31:0] ADDR_PERIODIC_START = 32'hB000_7040;

    // ==================================================================
    // field layouts
    localparam logic [31:0] IRQ_BITS_MASK = 32'hC000_006F; // bit 4 absent
    localparam int MASTER_IRQ_BIT = 31;
    localparam logic [31:0] COMM_AREA_MASK = 32'hFFFF_FF80;
    localparam logic [31:0] DESC_PTR_MASK = 32'hFFFF_FFF0;
    localparam int TOGGLE_BIT = 31;
    localparam int PKT_LIMIT_LSB = 16;
    localparam int PKT_LIMIT_W = 15;
    localparam int FRAME_TIME_W = 14;
    localparam int FRAME_COUNT_W = 16;

    // ==================================================================
    // values after reset
    localparam logic [31:0] IRQ_ENABLE_RESET = 32'h0000_0000;
    localparam logic [31:0] PTR_RESET = 32'h0000_0000;
    localparam logic [31:0] FRAME_INTERVAL_RESET = 32'h0000_2EDF;
    localparam logic [13:0] PERIODIC_START_RESET = 14'h0000;

    // ==================================================================
    // functional state and timing
    localparam logic [1:0] FSTATE_RUNNING = 2'h2;
    localparam int unsigned PCLK_KHZ = 125000;
    localparam int unsigned BIT_RATE_KHZ = 12000;

endpackage

`default_nettype wire

// file: verilog/uhl_bit_tick.sv
// fractional divider giving one pulse per 12 MHz bit time from pclk

`timescale 1ns/1ns
`default_nettype none

module uhl_bit_tick #(
    parameter int unsigned CLK_KHZ = uhl_pkg::PCLK_KHZ,
    parameter int unsigned TICK_KHZ = uhl_pkg::BIT_RATE_KHZ
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    import uhl_pkg::*;

    localparam int ACC_W = $clog2(CLK_KHZ + TICK_KHZ + 1);
    localparam logic [ACC_W-1:0] STEP = ACC_W'(TICK_KHZ);
    localparam logic [ACC_W-1:0] WRAP = ACC_W'(CLK_KHZ);

    // the tick must be slower than pclk, or pulses would merge
    initial begin
        if (TICK_KHZ == 0 || TICK_KHZ >= CLK_KHZ) begin
            $error("uhl_bit_tick: tick rate must be below clock rate");
        end
    end

    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] next_acc;
    logic next_tick;

    // phase accumulator: average rate exact, jitter one pclk period
    always_comb begin
        next_acc = acc + STEP;
        next_tick = 1'b0;
        if (next_acc >= WRAP) begin
            next_acc = next_acc - WRAP;
            next_tick = 1'b1;
        end
    end

    // accumulator and registered pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= '0;
            tick <= 1'b0;
        end else begin
            acc <= next_acc;
            tick <= next_tick;
        end
    end

endmodule

`default_nettype wire

// file: verilog/uhl_frame_regs.sv
// interrupt enable set, list pointers and frame timing with APB access
//
// Added by the designer: the APB interface to the registers.

`timescale 1ns/1ns
`default_nettype none

module uhl_frame_regs #(
    parameter int unsigned CLK_KHZ = uhl_pkg::PCLK_KHZ,
    parameter int unsigned BIT_KHZ = uhl_pkg::BIT_RATE_KHZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] func_state,
    output logic [31:0] irq_enable,
    output logic [31:0] comm_area_ptr,
    output logic [31:0] periodic_cur_ptr,
    output logic [31:0] control_head_ptr,
    output logic [31:0] control_cur_ptr,
    output logic [31:0] bulk_head_ptr,
    output logic [31:0] bulk_cur_ptr,
    output logic [31:0] done_head_ptr,
    output logic [uhl_pkg::PKT_LIMIT_W-1:0] largest_packet_limit,
    output logic largest_packet_load,
    output logic [uhl_pkg::FRAME_TIME_W-1:0] frame_time_count,
    output logic remaining_toggle,
    output logic [uhl_pkg::FRAME_COUNT_W-1:0] frame_count,
    output logic [uhl_pkg::FRAME_TIME_W-1:0] periodic_begin_point,
    output logic periodic_begin_hit,
    output logic frame_start_event,
    output logic frame_wrap_event
);
    import uhl_pkg::*;

    // ==================================================================
    // elaboration checks
    initial begin
        if (BIT_KHZ == 0 || BIT_KHZ >= CLK_KHZ) begin
            $error("uhl_frame_regs: bit rate must be below pclk rate");
        end
    end

    // ==================================================================
    // state of the block, registered as one word
    typedef struct packed {
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic [31:0] ien;
        logic [31:0] comm;
        logic [31:0] per_cur;
        logic [31:0] ctl_head;
        logic [31:0] ctl_cur;
        logic [31:0] blk_head;
        logic [31:0] blk_cur;
        logic [31:0] done;
        logic intv_toggle;
        logic [PKT_LIMIT_W-1:0] pkt_limit;
        logic [FRAME_TIME_W-1:0] frame_len;
        logic rem_toggle;
        logic [FRAME_TIME_W-1:0] rem;
        logic [FRAME_COUNT_W-1:0] fnum;
        logic [FRAME_TIME_W-1:0] per_start;
        logic was_running;
        logic pkt_load;
        logic per_hit;
        logic sof;
        logic wrap;
    } uhl_state_t;

    uhl_state_t st;
    uhl_state_t next_st;
    logic bit_tick;

    // ==================================================================
    // helpers
    // true when the address is one this bank answers
    function automatic logic uhl_mapped(input logic [31:0] a);
        case (a)
            ADDR_IRQ_ENABLE, ADDR_IRQ_DISABLE, ADDR_COMM_AREA,
            ADDR_PERIODIC_CUR, ADDR_CONTROL_HEAD, ADDR_CONTROL_CUR,
            ADDR_BULK_HEAD, ADDR_BULK_CUR, ADDR_DONE_HEAD,
            ADDR_FRAME_INTERVAL, ADDR_FRAME_LEFT, ADDR_FRAME_COUNT,
            ADDR_PERIODIC_START: uhl_mapped = 1'b1;
            default: uhl_mapped = 1'b0;
        endcase
    endfunction

    // 16-byte aligned descriptor pointer, reserved low bits zero
    function automatic logic [31:0] uhl_desc(input logic [31:0] d);
        uhl_desc = d & DESC_PTR_MASK;
    endfunction

    // read image of the frame interval register
    function automatic logic [31:0] uhl_intv_word(input uhl_state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[TOGGLE_BIT] = s.intv_toggle;
        w[PKT_LIMIT_LSB +: PKT_LIMIT_W] = s.pkt_limit;
        w[FRAME_TIME_W-1:0] = s.frame_len;
        uhl_intv_word = w;
    endfunction

    // ==================================================================
    // 12 MHz bit time strobe
    uhl_bit_tick #(
        .CLK_KHZ(CLK_KHZ),
        .TICK_KHZ(BIT_KHZ)
    ) u_bit_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(bit_tick)
    );

    // ==================================================================
    // next state: bus slave, register writes and frame timing
    always_comb begin
        logic setup;
        logic access;
        logic wr;
        logic running;
        logic load;
        logic [FRAME_TIME_W-1:0] dec;
        logic [FRAME_COUNT_W-1:0] fnum_inc;

        next_st = st;
        setup = psel && !penable;
        access = psel && penable && st.ready;
        wr = access && pwrite && !st.err;
        running = (func_state == FSTATE_RUNNING);
        load = 1'b0;
        dec = st.rem - 14'h0001;
        fnum_inc = st.fnum + 16'h0001;

        // answer one cycle after setup: pready high for the first
        // access cycle only, so every transfer takes two cycles
        next_st.ready = setup;
        next_st.err = setup && !uhl_mapped(paddr);
        next_st.rdata = 32'h0000_0000;
        if (setup && !pwrite) begin
            case (paddr)
                ADDR_IRQ_ENABLE: next_st.rdata = st.ien;
                ADDR_IRQ_DISABLE: next_st.rdata = st.ien;
                ADDR_COMM_AREA: next_st.rdata = st.comm;
                ADDR_PERIODIC_CUR: next_st.rdata = st.per_cur;
                ADDR_CONTROL_HEAD: next_st.rdata = st.ctl_head;
                ADDR_CONTROL_CUR: next_st.rdata = st.ctl_cur;
                ADDR_BULK_HEAD: next_st.rdata = st.blk_head;
                ADDR_BULK_CUR: next_st.rdata = st.blk_cur;
                ADDR_DONE_HEAD: next_st.rdata = st.done;
                ADDR_FRAME_INTERVAL: next_st.rdata = uhl_intv_word(st);
                ADDR_FRAME_LEFT: begin
                    next_st.rdata[TOGGLE_BIT] = st.rem_toggle;
                    next_st.rdata[FRAME_TIME_W-1:0] = st.rem;
                end
                ADDR_FRAME_COUNT: next_st.rdata[FRAME_COUNT_W-1:0] = st.fnum;
                ADDR_PERIODIC_START: begin
                    next_st.rdata[FRAME_TIME_W-1:0] = st.per_start;
                end
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end

        // writes land at the access edge; read-only words ignore them
        if (wr) begin
            case (paddr)
                // enable side sets bits; the absent fatal error bit is
                // masked out so it always reads zero
                ADDR_IRQ_ENABLE: begin
                    next_st.ien = st.ien | (pwdata & IRQ_BITS_MASK);
                end
                // one clears the matching enable, zero leaves it alone;
                // bit 31 drops the global enable itself
                ADDR_IRQ_DISABLE: begin
                    next_st.ien = st.ien & ~(pwdata & IRQ_BITS_MASK);
                end
                ADDR_COMM_AREA: next_st.comm = pwdata & COMM_AREA_MASK;
                ADDR_PERIODIC_CUR: next_st.per_cur = uhl_desc(pwdata);
                ADDR_CONTROL_HEAD: next_st.ctl_head = uhl_desc(pwdata);
                ADDR_CONTROL_CUR: next_st.ctl_cur = uhl_desc(pwdata);
                ADDR_BULK_HEAD: next_st.blk_head = uhl_desc(pwdata);
                ADDR_BULK_CUR: next_st.blk_cur = uhl_desc(pwdata);
                ADDR_DONE_HEAD: next_st.done = uhl_desc(pwdata);
                // toggle is stored as written; flipping it is up to
                // software, the timer only copies it at the next load
                ADDR_FRAME_INTERVAL: begin
                    next_st.intv_toggle = pwdata[TOGGLE_BIT];
                    next_st.pkt_limit = pwdata[PKT_LIMIT_LSB +: PKT_LIMIT_W];
                    next_st.frame_len = pwdata[FRAME_TIME_W-1:0];
                end
                ADDR_PERIODIC_START: begin
                    next_st.per_start = pwdata[FRAME_TIME_W-1:0];
                end
                default: next_st.done = st.done;
            endcase
        end

        // frame timer: load on entry to running, else count bit times
        next_st.was_running = running;
        next_st.per_hit = 1'b0;
        if (running && !st.was_running) begin
            load = 1'b1;
        end else if (running && bit_tick) begin
            if (st.rem == 14'h0000) begin
                load = 1'b1;
            end else begin
                next_st.rem = dec;
                // list processor starts periodic work at this point
                next_st.per_hit = (dec == st.per_start);
            end
        end

        // every load opens a frame: copy toggle, bump the frame count,
        // restart the packet limit and report the new frame
        next_st.pkt_load = load;
        next_st.sof = load;
        next_st.wrap = 1'b0;
        if (load) begin
            next_st.rem = st.frame_len;
            next_st.rem_toggle = st.intv_toggle;
            next_st.fnum = fnum_inc;
            next_st.wrap = fnum_inc[15] != st.fnum[15];
        end
    end

    // ==================================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.ien <= IRQ_ENABLE_RESET;
            st.comm <= PTR_RESET;
            st.per_cur <= PTR_RESET;
            st.ctl_head <= PTR_RESET;
            st.ctl_cur <= PTR_RESET;
            st.blk_head <= PTR_RESET;
            st.blk_cur <= PTR_RESET;
            st.done <= PTR_RESET;
            st.intv_toggle <= FRAME_INTERVAL_RESET[TOGGLE_BIT];
            st.pkt_limit <= FRAME_INTERVAL_RESET[PKT_LIMIT_LSB +: PKT_LIMIT_W];
            st.frame_len <= FRAME_INTERVAL_RESET[FRAME_TIME_W-1:0];
            st.per_start <= PERIODIC_START_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ==================================================================
    // outputs, each straight from the state register
    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.err;
    assign irq_enable = st.ien;
    assign comm_area_ptr = st.comm;
    assign periodic_cur_ptr = st.per_cur;
    assign control_head_ptr = st.ctl_head;
    assign control_cur_ptr = st.ctl_cur;
    assign bulk_head_ptr = st.blk_head;
    assign bulk_cur_ptr = st.blk_cur;
    assign done_head_ptr = st.done;
    // the limit is sampled by the packet counter on the load pulse
    assign largest_packet_limit = st.pkt_limit;
    assign largest_packet_load = st.pkt_load;
    assign frame_time_count = st.rem;
    assign remaining_toggle = st.rem_toggle;
    assign frame_count = st.fnum;
    assign periodic_begin_point = st.per_start;
    assign periodic_begin_hit = st.per_hit;
    assign frame_start_event = st.sof;
    assign frame_wrap_event = st.wrap;

endmodule

`default_nettype wire

// file: verification/uhl_frame_regs_sva.sv
// port assertions for the list pointer and frame timing register bank
`timescale 1ns/1ns
`default_nettype none
module uhl_frame_regs_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] func_state,
    input wire logic [31:0] irq_enable,
    input wire logic [31:0] comm_area_ptr,
    input wire logic [31:0] periodic_cur_ptr,
    input wire logic [31:0] control_head_ptr,
    input wire logic [31:0] control_cur_ptr,
    input wire logic [31:0] bulk_head_ptr,
    input wire logic [31:0] bulk_cur_ptr,
    input wire logic [31:0] done_head_ptr,
    input wire logic largest_packet_load,
    input wire logic [13:0] frame_time_count,
    input wire logic [15:0] frame_count,
    input wire logic [13:0] periodic_begin_point,
    input wire logic periodic_begin_hit,
    input wire logic frame_start_event,
    input wire logic frame_wrap_event
);
    import uhl_pkg::*;
    // ==============================================================
    // one clock domain, so clock and reset are given once
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_irq_bits;
        (irq_enable & ~IRQ_BITS_MASK) == 32'h0000_0000;
    endproperty
    a_irq_bits: assert property (p_irq_bits) else $error("stray enable bit");
    property p_comm;
        comm_area_ptr[6:0] == 7'h00;
    endproperty
    a_comm: assert property (p_comm) else $error("comm low bits set");
    property p_done;
        done_head_ptr[3:0] == 4'h0;
    endproperty
    a_done: assert property (p_done) else $error("done low bits set");
    // list pointers are 16-byte aligned, reserved low bits never set
    property p_desc;
        {periodic_cur_ptr[3:0], control_head_ptr[3:0], control_cur_ptr[3:0],
            bulk_head_ptr[3:0], bulk_cur_ptr[3:0]} == 20'h00000;
    endproperty
    a_desc: assert property (p_desc) else $error("list ptr low bits set");
    // entry into the running state must load the timer at the next edge
    property p_enter;
        func_state == FSTATE_RUNNING && $past(func_state) != FSTATE_RUNNING
            |=> frame_start_event;
    endproperty
    a_enter: assert property (p_enter) else $error("no load on entry");
    // outside a load the timer only steps down by one, and only when running
    property p_step;
        !frame_start_event && frame_time_count != $past(frame_time_count)
            |-> $past(func_state) == FSTATE_RUNNING
            && frame_time_count == $past(frame_time_count) - 14'h0001;
    endproperty
    a_step: assert property (p_step) else $error("bad timer step");
    property p_reload;
        $past(frame_time_count) == 14'h0000 && frame_time_count != 14'h0000
            |-> frame_start_event;
    endproperty
    a_reload: assert property (p_reload) else $error("zero not reloaded");
    property p_count;
        frame_start_event || frame_count != $past(frame_count)
            |-> frame_start_event && frame_count == $past(frame_count) + 16'h1;
    endproperty
    a_count: assert property (p_count) else $error("frame count off");
    property p_wrap;
        frame_wrap_event == (frame_start_event
            && frame_count[15] != $past(frame_count[15]));
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap pulse wrong");
    property p_limit;
        largest_packet_load == frame_start_event;
    endproperty
    a_limit: assert property (p_limit) else $error("limit load wrong");
    property p_hit;
        periodic_begin_hit |-> !frame_start_event
            && frame_time_count == periodic_begin_point;
    endproperty
    a_hit: assert property (p_hit) else $error("periodic hit wrong");
endmodule
bind uhl_frame_regs uhl_frame_regs_sva i_sva (.pclk, .presetn, .func_state,
    .irq_enable, .comm_area_ptr, .periodic_cur_ptr, .control_head_ptr,
    .control_cur_ptr, .bulk_head_ptr, .bulk_cur_ptr,
    .done_head_ptr, .largest_packet_load,
    .frame_time_count, .frame_count, .periodic_begin_point,
    .periodic_begin_hit, .frame_start_event, .frame_wrap_event);
`default_nettype wire

// file: verification/uhl_frame_regs_tb_top.sv
// self-checking bench for the list pointer and frame timing registers
`timescale 1ns/1ns
`default_nettype none
module uhl_frame_regs_tb_top;
    import uhl_pkg::*;
    typedef struct packed {logic w; logic e; logic [31:0] d;} uhl_note_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic remaining_toggle, frame_start_event, exp_tog;
    logic [31:0] paddr, pwdata, prdata, irq_enable, r, m;
    logic [31:0] seed = 32'h052E;
    logic [1:0] func_state;
    logic [14:0] largest_packet_limit, exp_lim;
    logic [13:0] frame_time_count, exp_len;
    logic [15:0] frame_count;
    int n_errors, total_checks, exp_fc;
    int srcs[7] = '{30, 6, 5, 3, 2, 1, 0};
    uhl_note_t notes[$];
    uhl_note_t note;
    // fast bit tick (every other pclk) keeps frames short
    uhl_frame_regs #(.BIT_KHZ(62500)) i_uhl_frame_regs (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .func_state, .irq_enable, .comm_area_ptr(),
        .periodic_cur_ptr(), .control_head_ptr(), .control_cur_ptr(),
        .bulk_head_ptr(), .bulk_cur_ptr(), .done_head_ptr(),
        .largest_packet_limit, .largest_packet_load(), .frame_time_count,
        .remaining_toggle, .frame_count, .periodic_begin_point(),
        .periodic_begin_hit(), .frame_start_event, .frame_wrap_event());
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // ==============================================================
    // helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // request held until pready is sampled high, released after that edge
    task automatic apb(input logic w, input logic [31:0] a, d, exp,
                       input logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        notes.push_back({w, e, exp});
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [31:0] a, exp);
        apb(1'b0, a, 32'h0, exp, 1'b0);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ==============================================================
    // watcher: bus answers against notes, frame loads against model
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            note = notes.pop_front();
            if (!note.w) chk("prdata", note.d, prdata);
            chk("pslverr", {31'h0, note.e}, {31'h0, pslverr});
        end
        if (frame_start_event === 1'b1) begin
            exp_fc = exp_fc + 1;
            chk("frame_count", exp_fc, {16'h0, frame_count});
            chk("time_left", {exp_tog, 17'h0, exp_len},
                {remaining_toggle, 17'h0, frame_time_count});
            chk("pkt_limit", {17'h0, exp_lim}, {17'h0, largest_packet_limit});
        end
    end
    // hang guard, far beyond the expected run length
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
    // ==============================================================
    // main sequence
    initial begin
        {psel, penable, pwrite} = 3'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        func_state = 2'h0;
        presetn = 1'b0;
        {n_errors, total_checks, exp_fc} = '0;
        {exp_tog, exp_lim, exp_len} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 13; i++)
            rd(ADDR_IRQ_ENABLE + 4 * i, i == 9 ? FRAME_INTERVAL_RESET : 0);
        $display("test reset values done");
        for (int i = 2; i < 9; i++) begin
            r = xs();
            m = (i == 2) ? COMM_AREA_MASK : DESC_PTR_MASK;
            wr(ADDR_IRQ_ENABLE + 4 * i, r);
            rd(ADDR_IRQ_ENABLE + 4 * i, r & m);
        end
        wr(ADDR_PERIODIC_START, 32'hFFFF_FFFF);
        rd(ADDR_PERIODIC_START, 32'h0000_3FFF);
        $display("test pointers done");
        wr(ADDR_IRQ_ENABLE, 32'hFFFF_FFFF);
        rd(ADDR_IRQ_DISABLE, IRQ_BITS_MASK);
        wr(ADDR_IRQ_DISABLE, 32'h0000_0010);
        rd(ADDR_IRQ_DISABLE, IRQ_BITS_MASK);
        wr(ADDR_IRQ_DISABLE, 32'h8000_0000);
        m = 32'h4000_006F;
        rd(ADDR_IRQ_ENABLE, m);
        foreach (srcs[k]) begin
            m[srcs[k]] = 1'b0;
            wr(ADDR_IRQ_DISABLE, 32'h1 << srcs[k]);
            rd(ADDR_IRQ_DISABLE, m);
        end
        chk("irq_enable", 32'h0, irq_enable);
        $display("test interrupt enables done");
        apb(1'b1, 32'hB000_7044, 32'h1, 32'h0, 1'b1);
        apb(1'b0, 32'hB000_700C, 32'h0, 32'h0, 1'b1);
        wr(ADDR_FRAME_COUNT, 32'h0000_FFFF);
        rd(ADDR_FRAME_COUNT, 32'h0);
        $display("test refusals done");
        // short frame so several reloads fit in the run
        {exp_tog, exp_lim, exp_len} = {1'b1, 15'h1234, 14'd20};
        wr(ADDR_FRAME_INTERVAL, {exp_tog, exp_lim, 2'b00, exp_len});
        wr(ADDR_PERIODIC_START, 32'h5);
        @(posedge pclk);
        func_state <= FSTATE_RUNNING;
        for (int i = 0; i < 400 && exp_fc < 3; i++) @(posedge pclk);
        @(posedge pclk iff frame_start_event === 1'b1);
        wr(ADDR_FRAME_INTERVAL, {1'b0, 15'h0555, 2'b00, 14'd30});
        {exp_tog, exp_lim, exp_len} = {1'b0, 15'h0555, 14'd30};
        for (int i = 0; i < 400 && exp_fc < 6; i++) @(posedge pclk);
        func_state <= 2'h0;
        repeat (3) @(posedge pclk);
        rd(ADDR_FRAME_COUNT, exp_fc);
        func_state <= FSTATE_RUNNING;
        repeat (3) @(posedge pclk);
        chk("reentry loads", 32'd7, exp_fc);
        $display("test frame timing done");
        conclude();
    end
endmodule
`default_nettype wire
